//--- bench/dlp_dev_model.sv
// Purpose: behavioural model of the programmable delay element
// Assumes: no clock of its own, reacts to pin edges
// Notes:   data-out loops to data-in through a resistor when the host lets go
`timescale 1ns/10ps
module dlp_dev_model (
   input  wire dlp_pkg::dlp_pins_t i_pins,
   output wire logic               o_q,
   output logic [7:0]              o_code,
   output logic [7:0]              o_shift
);
   logic en;
   logic d;
   logic hu_prev;
   initial o_shift = 8'h00;
   initial o_code = 8'h00;
   initial hu_prev = 1'b0;
   assign en = i_pins.serial_sel & i_pins.hold_update;
   assign d = i_pins.code_oe[2] ? i_pins.code_out[2] : o_q;
   // released pin shows the inverse so a stale value never passes
   assign #20 o_q = en ? o_shift[7] : ~o_shift[7];
   always @(posedge i_pins.code_out[1]) begin
      if (en) o_shift <= {o_shift[6:0], d};
   end
   always @(i_pins) begin
      if (!i_pins.serial_sel && i_pins.hold_update) o_code = i_pins.code_out;
      if (i_pins.serial_sel && hu_prev && !i_pins.hold_update) o_code = o_shift;
      hu_prev = i_pins.hold_update;
   end
endmodule

//--- bench/dlp_host_asserts.sv
// Purpose: pin timing checks for the delay line host
// Assumes: bound to dlp_host, one clock domain
// Notes:   widths in cycles of 10 ns
`timescale 1ns/10ps
module dlp_host_asserts (
   input wire logic               i_clk,
   input wire logic               i_reset_n,
   input wire logic               i_rd,
   input wire logic [31:0]        o_rdata,
   input wire dlp_pkg::dlp_pins_t o_pins
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data not idle");
   par_drive_a: assert property (
      !o_pins.serial_sel && o_pins.hold_update |-> o_pins.code_oe == 8'hFF)
      else $error("parallel code not driven");
   q_free_a: assert property (
      o_pins.serial_sel && o_pins.hold_update |-> !o_pins.code_oe[0])
      else $error("data-out pin driven");
   clk_hi_a: assert property (
      $rose(o_pins.code_out[1]) && o_pins.serial_sel |-> o_pins.code_out[1][*5])
      else $error("serial clock high too short");
   clk_lo_a: assert property (
      $fell(o_pins.code_out[1]) && o_pins.serial_sel && o_pins.hold_update
      |-> (!o_pins.code_out[1])[*5])
      else $error("serial clock low too short");
   hold_wide_a: assert property (
      $rose(o_pins.hold_update) |-> o_pins.hold_update[*5])
      else $error("hold pulse too short");
   data_setup_a: assert property (
      $rose(o_pins.code_out[1]) && o_pins.serial_sel && o_pins.code_oe[2]
      |-> o_pins.code_out[2] == $past(o_pins.code_out[2], 3))
      else $error("data moved before clock");
   start_low_a: assert property (
      $rose(o_pins.hold_update) && o_pins.serial_sel |-> !o_pins.code_out[1])
      else $error("hold rose with clock high");
   end_low_a: assert property (
      $fell(o_pins.hold_update) && o_pins.serial_sel
      |-> !$past(o_pins.code_out[1], 3))
      else $error("hold fell too soon after clock");
   cover property ($rose(o_pins.hold_update) && o_pins.serial_sel);
   cover property ($rose(o_pins.hold_update) && !o_pins.serial_sel);
   cover property ($rose(o_pins.code_out[1]) && !o_pins.code_oe[2]);
endmodule
bind dlp_host dlp_host_asserts u_dlp_host_asserts (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_pins(o_pins));

//--- bench/dlp_host_tb_top.sv
// Purpose: self-checking bench for the delay line host
// Assumes: device model on the pins
// Notes:   settle shortened to 4 cycles
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module dlp_host_tb_top;
   logic               i_clk = 1'b0;
   logic               i_reset_n = 1'b0;
   logic [3:0]         i_addr = 4'h0;
   logic [31:0]        i_wdata = 32'h0;
   logic               i_wr = 1'b0;
   logic               i_rd = 1'b0;
   logic [31:0]        o_rdata;
   dlp_pkg::dlp_pins_t o_pins;
   logic               q;
   logic               sdo;
   logic [7:0]         dev_code;
   logic [7:0]         dev_shift;
   logic [31:0]        r;
   logic [9:0]         rows [6] = '{10'h000, 10'h1A5, 10'h0FF, 10'h23C, 10'h381, 10'h2FF};
   int                 fails = 0;
   int                 checked = 0;
   int                 cyc = 0;
   int                 rises = 0;
   always #5 i_clk = ~i_clk;
   assign sdo = o_pins.code_oe[0] ? o_pins.code_out[0] : q;
   dlp_host #(.SETTLE_CYCLES(4)) u_dlp_host (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_serial_data_out(sdo), .o_pins(o_pins));
   dlp_dev_model u_dlp_dev_model (.i_pins(o_pins), .o_q(q), .o_code(dev_code),
      .o_shift(dev_shift));
   always @(posedge o_pins.code_out[1]) if (o_pins.serial_sel && o_pins.hold_update) rises++;
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_clk);
   endtask
   // polls status; settle time counts as busy for ordering
   task automatic idle();
      r = 32'h3;
      for (int k = 0; k < 300 && r[1:0] !== 2'b00; k++) rd(dlp_pkg::REG_STATUS, r);
      `CHK("status", 2'b00, r[1:0])
   endtask
   task automatic stop_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(posedge i_clk);
      `CHK("pins_rst", 19'h0, o_pins)
      `CHK("rdata_rst", 32'h0, o_rdata)
      repeat (6) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      rd(dlp_pkg::REG_STATUS, r);
      `CHK("status_rst", 32'h0, r)
      for (int i = 0; i < 6; i++) begin
         rises = 0;
         wr(dlp_pkg::REG_CHAIN, 32'h0);
         wr(dlp_pkg::REG_CODE, {24'h0, rows[i][7:0]});
         wr(dlp_pkg::REG_CTRL, {28'h0, 2'b01, rows[i][8], rows[i][9]});
         idle();
         `CHK("code", rows[i][7:0], dev_code)
         `CHK("mode", rows[i][9], o_pins.serial_sel)
         `CHK("ofs", rows[i][8], o_pins.output_function_select)
         `CHK("rises", rows[i][9] ? 8 : 0, rises)
         if (rows[i][9]) begin
            wr(dlp_pkg::REG_CTRL, {28'h0, 2'b10, rows[i][8], 1'b1});
            idle();
            rd(dlp_pkg::REG_READ, r);
            `CHK("readback", rows[i][7:0], r[7:0])
            `CHK("restored", rows[i][7:0], dev_shift)
            `CHK("kept", rows[i][7:0], dev_code)
         end
      end
      rises = 0;
      wr(dlp_pkg::REG_CHAIN, 32'h1);
      wr(dlp_pkg::REG_CODE, 32'h55);
      wr(dlp_pkg::REG_CTRL, 32'h5);
      rd(dlp_pkg::REG_STATUS, r);
      `CHK("busy", 1'b1, r[0])
      wr(dlp_pkg::REG_CODE, 32'h0);
      idle();
      `CHK("chain_code", 8'h55, dev_code)
      `CHK("chain_rises", 16, rises)
      rd(dlp_pkg::REG_CODE, r);
      `CHK("busy_wr", 32'h55, r)
      rd(4'hF, r);
      `CHK("unmapped", 32'h0, r)
      rd(dlp_pkg::REG_CTRL, r);
      `CHK("ctrl", 32'h1, r)
      rd(dlp_pkg::REG_CHAIN, r);
      `CHK("chain", 32'h1, r)
      // reset in mid-transfer must drop every pin at once
      wr(dlp_pkg::REG_CTRL, 32'h5);
      repeat (30) @(posedge i_clk);
      i_reset_n <= 1'b0;
      @(posedge i_clk);
      `CHK("pins_mid", 19'h0, o_pins)
      `CHK("rdata_mid", 32'h0, o_rdata)
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      rd(dlp_pkg::REG_STATUS, r);
      `CHK("status_mid", 32'h0, r)
      rd(dlp_pkg::REG_CHAIN, r);
      `CHK("chain_mid", 32'h0, r)
      stop_test();
   end
endmodule

//--- inc/dlp_pkg.sv
// Purpose: constants and carrier types for the delay line programming controller
// Assumes: 100 MHz system clock
// Notes:   timing figures in ns, cycle counts derived from them
package dlp_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned CODE_W          = 8;
   localparam int unsigned MAX_CHAIN       = 16;
   localparam int unsigned CHAIN_W         = 4;
   // serial clock at most 10 MHz: half period 50 ns, also the least pulse width
   localparam int unsigned MIN_PULSE_NS    = 50;
   localparam int unsigned PULSE_CYC       = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EQV_NS          = 50;
   localparam int unsigned EQV_CYC         = (EQV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETUP_NS        = 30;
   localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_NS       = 1000;
   localparam int unsigned SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TMR_W           = 16;
   localparam int unsigned BITCNT_W        = 8;

   // software register map (word index on a 4-bit address)
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_CODE    = 4'h1;
   localparam logic [3:0] REG_STATUS  = 4'h2;
   localparam logic [3:0] REG_READ    = 4'h3;
   localparam logic [3:0] REG_CHAIN   = 4'h4;
   // control register fields
   localparam int unsigned CTRL_SERIAL  = 0;
   localparam int unsigned CTRL_OFS     = 1;
   localparam int unsigned CTRL_GO_WR   = 2;
   localparam int unsigned CTRL_GO_RD   = 3;
   // status fields
   localparam int unsigned ST_BUSY      = 0;
   localparam int unsigned ST_SETTLING  = 1;

   typedef struct packed {
      logic       hold_update;
      logic       serial_sel;
      logic       output_function_select;
      logic [7:0] code_out;
      logic [7:0] code_oe;
   } dlp_pins_t;
endpackage

//--- logic/dlp_host.sv
// Purpose: host controller that programs an 8-bit delay element (parallel or serial)
// Assumes: single 100 MHz clock; data-out pin returns from the device asynchronously
// Notes:   one instance drives a whole daisy chain; readback loops through a resistor
// How it works
// - shift msb first on rising serial clock
// - clock eight bits per chained unit
// - raise hold-update with clock low, wait
// - eight clocks per package restore register
// - release data driver during readback
// - wait settling interval after code change
// - no retrigger before pulse ends
// - serial clock at most 10 MHz, 50 ns
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
module dlp_host #(
   parameter int unsigned SETTLE_CYCLES = dlp_pkg::SETTLE_CYC
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_reset_n,
   input  wire logic [3:0]                i_addr,
   input  wire logic [31:0]               i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   output logic [31:0]                    o_rdata,
   input  wire logic                      i_serial_data_out,
   output dlp_pkg::dlp_pins_t             o_pins
);
   typedef enum logic [2:0] {S_IDLE, S_OPEN, S_LOW, S_HIGH, S_CLOSE, S_SETTLE} dlp_state_t;

   // pin synchroniser: only stage two is read
   logic sync1_q, sync2_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= i_serial_data_out;
         sync2_q <= sync1_q;
      end
   end

   dlp_state_t                       state_q, state_d;
   logic                             serial_q, serial_d, ofs_q, ofs_d, read_q, read_d;
   logic [dlp_pkg::CODE_W-1:0]       code_q, code_d, rdbk_q, rdbk_d;
   logic [dlp_pkg::CHAIN_W-1:0]      chain_q, chain_d;
   logic [dlp_pkg::BITCNT_W-1:0]     bits_q, bits_d;
   logic [dlp_pkg::TMR_W-1:0]        tmr_q, tmr_d;
   logic                             le_q, le_d, sck_q, sck_d, sdi_q, sdi_d, sdi_oe_q, sdi_oe_d;
   logic [31:0]                      rdata_q, rdata_d;

   logic [dlp_pkg::BITCNT_W-1:0] total_bits;
   // chain register holds units minus one, so at least one unit is always sent
   assign total_bits = dlp_pkg::BITCNT_W'({chain_q, 3'h0}) + dlp_pkg::BITCNT_W'(dlp_pkg::CODE_W);

   always_comb begin
      state_d  = state_q;
      serial_d = serial_q;
      ofs_d    = ofs_q;
      read_d   = read_q;
      code_d   = code_q;
      rdbk_d   = rdbk_q;
      chain_d  = chain_q;
      bits_d   = bits_q;
      tmr_d    = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
      le_d     = le_q;
      sck_d    = sck_q;
      sdi_d    = sdi_q;
      sdi_oe_d = sdi_oe_q;
      rdata_d  = 32'h0;
      // writes while busy are dropped so a transfer never sees a half-changed code
      if (i_wr && state_q == S_IDLE) begin
         unique case (i_addr)
            dlp_pkg::REG_CTRL: begin
               serial_d = i_wdata[dlp_pkg::CTRL_SERIAL];
               ofs_d    = i_wdata[dlp_pkg::CTRL_OFS];
               if (i_wdata[dlp_pkg::CTRL_GO_WR] || i_wdata[dlp_pkg::CTRL_GO_RD]) begin
                  read_d   = i_wdata[dlp_pkg::CTRL_GO_RD];
                  // raise hold-update with serial clock low
                  le_d     = 1'b1;
                  sck_d    = 1'b0;
                  sdi_oe_d = !i_wdata[dlp_pkg::CTRL_GO_RD];
                  bits_d   = '0;
                  tmr_d    = dlp_pkg::TMR_W'(dlp_pkg::EQV_CYC);
                  state_d  = S_OPEN;
               end
            end
            dlp_pkg::REG_CODE:  code_d  = i_wdata[dlp_pkg::CODE_W-1:0];
            dlp_pkg::REG_CHAIN: chain_d = i_wdata[dlp_pkg::CHAIN_W-1:0];
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            dlp_pkg::REG_CTRL:   rdata_d = {30'h0, ofs_q, serial_q};
            dlp_pkg::REG_CODE:   rdata_d = {24'h0, code_q};
            dlp_pkg::REG_STATUS: rdata_d = {30'h0, state_q == S_SETTLE, state_q != S_IDLE};
            dlp_pkg::REG_READ:   rdata_d = {24'h0, rdbk_q};
            dlp_pkg::REG_CHAIN:  rdata_d = {28'h0, chain_q};
            default:             rdata_d = 32'h0;
         endcase
      end
      unique case (state_q)
         S_IDLE: ;
         S_OPEN: begin
            if (!serial_q) begin
               // code pins presented while hold-update high
               if (tmr_q == '0) begin
                  le_d    = 1'b0;
                  // data pin left free so a later serial read sees the loop resistor
                  sdi_oe_d = 1'b0;
                  tmr_d   = dlp_pkg::TMR_W'(SETTLE_CYCLES);
                  state_d = S_SETTLE;
               end
            end else if (tmr_q == '0) begin
               // data bit set up with clock low; msb of the current unit first
               if (!read_q)
                  sdi_d = code_q[3'(dlp_pkg::CODE_W - 1 - int'(bits_q[2:0]))];
               tmr_d   = dlp_pkg::TMR_W'(dlp_pkg::PULSE_CYC);
               state_d = S_LOW;
            end
         end
         S_LOW: if (tmr_q == '0) begin
            sck_d   = 1'b1;
            // sample the bit the device presents before this edge
            rdbk_d  = {rdbk_q[dlp_pkg::CODE_W-2:0], sync2_q};
            bits_d  = bits_q + 1'b1;
            tmr_d   = dlp_pkg::TMR_W'(dlp_pkg::PULSE_CYC);
            state_d = S_HIGH;
         end
         S_HIGH: if (tmr_q == '0) begin
            sck_d = 1'b0;
            // eight clocks per unit, also restores on readback
            if (bits_q == total_bits) begin
               tmr_d   = dlp_pkg::TMR_W'(dlp_pkg::SETUP_CYC);
               state_d = S_CLOSE;
            end else begin
               if (!read_q)
                  sdi_d = code_q[3'(dlp_pkg::CODE_W - 1 - int'(bits_q[2:0]))];
               tmr_d   = dlp_pkg::TMR_W'(dlp_pkg::PULSE_CYC);
               state_d = S_LOW;
            end
         end
         S_CLOSE: if (tmr_q == '0) begin
            le_d     = 1'b0;
            sdi_oe_d = 1'b0;
            // restored readback leaves the delay as it was
            tmr_d    = read_q ? '0 : dlp_pkg::TMR_W'(SETTLE_CYCLES);
            state_d  = S_SETTLE;
         end
         S_SETTLE: if (tmr_q == '0) state_d = S_IDLE;
         default:  state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q  <= S_IDLE;
         serial_q <= 1'b0;
         ofs_q    <= 1'b0;
         read_q   <= 1'b0;
         code_q   <= '0;
         rdbk_q   <= '0;
         chain_q  <= '0;
         bits_q   <= '0;
         tmr_q    <= '0;
         le_q     <= 1'b0;
         sck_q    <= 1'b0;
         sdi_q    <= 1'b0;
         sdi_oe_q <= 1'b0;
         rdata_q  <= 32'h0;
      end else begin
         state_q  <= state_d;
         serial_q <= serial_d;
         ofs_q    <= ofs_d;
         read_q   <= read_d;
         code_q   <= code_d;
         rdbk_q   <= rdbk_d;
         chain_q  <= chain_d;
         bits_q   <= bits_d;
         tmr_q    <= tmr_d;
         le_q     <= le_d;
         sck_q    <= sck_d;
         sdi_q    <= sdi_d;
         sdi_oe_q <= sdi_oe_d;
         rdata_q  <= rdata_d;
      end
   end

   // pin mux is registered so every output leaves a flip-flop
   dlp_pkg::dlp_pins_t pins_q, pins_d;
   always_comb begin
      pins_d.hold_update            = le_q;
      pins_d.serial_sel             = serial_q;
      pins_d.output_function_select = ofs_q;   // reference offset is device-side
      if (serial_q) begin
         pins_d.code_out = {5'h00, sdi_q, sck_q, 1'b0};
         pins_d.code_oe  = {5'h1F, sdi_oe_q, 1'b1, 1'b0}; // data-out pin left free
      end else begin
         pins_d.code_out = code_q;
         pins_d.code_oe  = 8'hFF;
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) pins_q <= '0;
      else            pins_q <= pins_d;
   end
   assign o_pins  = pins_q;
   assign o_rdata = rdata_q;
endmodule
